// [rtl/ttec_pkg.sv]
`default_nettype none
// ==========================================================
// register map and field layout
package ttec_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] TIMER_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] OUTPUT_CTRL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PRESCALER_SEL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] EDGE_SEL_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;
    // register select codes
    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_OUT = 3'h1;
    localparam logic [2:0] SEL_PRESC = 3'h2;
    localparam logic [2:0] SEL_EDGE = 3'h3;
    localparam logic [2:0] SEL_STAT = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h7;
    // timer control fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_ONESHOT_BIT = 1;
    localparam int CTRL_EXTCLK_BIT = 2;
    localparam int CTRL_CLRSTART_BIT = 3;
    localparam int CTRL_CAPTURE_BIT = 4;
    // output control fields
    localparam int OC_ENABLE_BIT = 0;
    localparam int OC_SET_BIT = 1;
    localparam int OC_RESET_BIT = 2;
    localparam int OC_TRIG_BIT = 3;
    // status fields
    localparam int ST_EDGE_BIT = 0;
    localparam int ST_INPUT_BIT = 1;
    localparam int ST_LEVEL_BIT = 2;
    // edge select encoding
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_NONE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int PRESC_W = 2;
    localparam int DIV_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
endpackage : ttec_pkg
`default_nettype wire

// [rtl/ttec_edge_detect.sv]
`timescale 1ns/100ps
`default_nettype none
module ttec_edge_detect (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // control
    input wire logic enable_i,
    input wire logic [1:0] edge_sel_i,
    // pin
    input wire logic level_i,
    // detected edges
    output logic rise_o,
    output logic fall_o,
    output logic edge_o
);
    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
    } ttec_edge_state_t;

    ttec_edge_state_t s_r, s_nxt;
    logic rise_sel;
    logic fall_sel;

    // ==========================================================
    // level compare
    assign rise_sel = (edge_sel_i == ttec_pkg::EDGE_RISE) || (edge_sel_i == ttec_pkg::EDGE_BOTH);
    assign fall_sel = (edge_sel_i == ttec_pkg::EDGE_FALL) || (edge_sel_i == ttec_pkg::EDGE_BOTH);

    always_comb begin
        s_nxt = s_r;
        // stored level frozen while stopped, so enabling sees a change [RULE12]
        if (enable_i) begin
            s_nxt.prev = level_i;
        end
        s_nxt.rise = enable_i && rise_sel && level_i && !s_r.prev; // [RULE7] [RULE9]
        s_nxt.fall = enable_i && fall_sel && !level_i && s_r.prev; // [RULE8]
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0; // stored level resets low [RULE12]
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rise_o = s_r.rise;
    assign fall_o = s_r.fall;
    assign edge_o = s_r.rise | s_r.fall;

    // ==========================================================
    // checks
    a_rise_at_enable: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE7]
        enable_i && rise_sel && level_i && !s_r.prev |=> rise_o)
        else $error("rising edge missed at enable");
    a_fall_at_enable: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE8]
        enable_i && fall_sel && !level_i && s_r.prev |=> fall_o)
        else $error("falling edge missed at enable");
    a_level_frozen: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE12]
        !enable_i |=> $stable(s_r.prev))
        else $error("stored level moved while stopped");
    a_quiet_stopped: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE9]
        !enable_i ##1 !enable_i |-> !edge_o)
        else $error("edge reported while stopped");
    c_rise_seen: cover property (@(posedge mclk_i) disable iff (!rst_n_i) !enable_i ##1 enable_i ##1 rise_o);
    c_fall_seen: cover property (@(posedge mclk_i) disable iff (!rst_n_i) !enable_i ##1 enable_i ##1 fall_o);
endmodule : ttec_edge_detect
`default_nettype wire

// [rtl/ttec_top.sv]
// How it works
// RULE1: software sets the soft trigger only in one-shot pulse mode.
// RULE2: successive soft trigger writes are two count clocks apart at least.
// RULE3: with output disabled, enable, set and reset bits written in one byte.
// RULE4: with output enabled, set and reset may be written on their own.
// RULE5: timer stopped before prescaler selection is changed.
// RULE6: external edge as count clock excludes clear-start and capture on it.
// RULE7: input high at first enable after reset gives an immediate rising edge.
// RULE8: stopped high, enabled low gives an immediate falling edge.
// RULE9: stopped low, enabled high gives an immediate rising edge.
// RULE10: soft trigger bit clears itself and reads zero.
// RULE11: output level set and reset bits always read zero.
// RULE12: edges compare input with a stored level, reset low, frozen when stopped.
`timescale 1ns/100ps
`default_nettype none
module ttec_top (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [ttec_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [ttec_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // axi4-lite write response
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // axi4-lite read
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [ttec_pkg::ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [ttec_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // pin
    input wire logic external_trigger_input_i,
    // to counter core
    output logic timer_run_o,
    output logic oneshot_mode_o,
    output logic count_tick_o,
    output logic oneshot_soft_trigger_o,
    output logic clear_start_o,
    output logic capture_o,
    output logic timer_output_enable_o,
    output logic output_level_o
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [ttec_pkg::ADDR_W-1:0] awaddr;
        logic [ttec_pkg::DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [ttec_pkg::DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic run;
        logic oneshot_mode;
        logic ext_clk;
        logic clr_start;
        logic cap_en;
        logic out_en;
        logic out_level;
        logic [ttec_pkg::PRESC_W-1:0] presc;
        logic [1:0] edge_sel;
        logic [ttec_pkg::DIV_W-1:0] div_cnt;
        logic trig;
        logic edge_flag;
    } ttec_state_t;

    ttec_state_t s_r, s_nxt;
    logic aw_hs, w_hs, ar_hs;
    logic edge_valid;
    logic presc_tick;
    logic [ttec_pkg::DIV_W-1:0] div_mask;

    // ==========================================================
    // helpers
    function automatic logic [2:0] ttec_reg_sel(input logic [ttec_pkg::ADDR_W-1:0] addr);
        case (addr)
            ttec_pkg::TIMER_CTRL_OFS: ttec_reg_sel = ttec_pkg::SEL_CTRL;
            ttec_pkg::OUTPUT_CTRL_OFS: ttec_reg_sel = ttec_pkg::SEL_OUT;
            ttec_pkg::PRESCALER_SEL_OFS: ttec_reg_sel = ttec_pkg::SEL_PRESC;
            ttec_pkg::EDGE_SEL_OFS: ttec_reg_sel = ttec_pkg::SEL_EDGE;
            ttec_pkg::STATUS_OFS: ttec_reg_sel = ttec_pkg::SEL_STAT;
            default: ttec_reg_sel = ttec_pkg::SEL_NONE;
        endcase
    endfunction : ttec_reg_sel

    // ==========================================================
    // edge detector on the pin
    ttec_edge_detect u_edge (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .enable_i(s_r.run),
        .edge_sel_i(s_r.edge_sel),
        .level_i(external_trigger_input_i),
        .rise_o(),
        .fall_o(),
        .edge_o(edge_valid)
    );

    // ==========================================================
    // bus handshakes
    assign s_axi_awready_o = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready_o = !s_r.w_got && !s_r.bvalid;
    assign s_axi_arready_o = !s_r.rvalid;
    assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
    assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;

    // prescaled tick: divide by 1, 2, 4 or 8
    assign div_mask = ttec_pkg::DIV_W'((1 << s_r.presc) - 1);
    assign presc_tick = (s_r.div_cnt & div_mask) == '0;

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.trig = 1'b0;
        s_nxt.div_cnt = s_r.div_cnt + 1'b1;
        if (aw_hs) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr_i;
        end
        if (w_hs) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata_i;
            s_nxt.wstrb = s_axi_wstrb_i;
        end
        if (s_r.bvalid && s_axi_bready_i) begin
            s_nxt.bvalid = 1'b0;
        end
        // write once both halves are held; all fields sit in byte lane 0
        if (s_r.aw_got && s_r.w_got) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = ttec_pkg::RESP_OKAY;
            case (ttec_reg_sel(s_r.awaddr))
                ttec_pkg::SEL_CTRL: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.run = s_r.wdata[ttec_pkg::CTRL_RUN_BIT];
                        s_nxt.oneshot_mode = s_r.wdata[ttec_pkg::CTRL_ONESHOT_BIT];
                        s_nxt.ext_clk = s_r.wdata[ttec_pkg::CTRL_EXTCLK_BIT];
                        s_nxt.clr_start = s_r.wdata[ttec_pkg::CTRL_CLRSTART_BIT];
                        s_nxt.cap_en = s_r.wdata[ttec_pkg::CTRL_CAPTURE_BIT];
                    end
                end
                ttec_pkg::SEL_OUT: begin
                    // set and reset act in any enable state, one byte write or alone [RULE4]
                    if (s_r.wstrb[0]) begin
                        s_nxt.out_en = s_r.wdata[ttec_pkg::OC_ENABLE_BIT];
                        if (s_r.wdata[ttec_pkg::OC_SET_BIT]) begin
                            s_nxt.out_level = 1'b1;
                        end else if (s_r.wdata[ttec_pkg::OC_RESET_BIT]) begin
                            s_nxt.out_level = 1'b0;
                        end
                        // one-cycle strobe, never stored [RULE10]
                        s_nxt.trig = s_r.wdata[ttec_pkg::OC_TRIG_BIT];
                    end
                end
                ttec_pkg::SEL_PRESC: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.presc = s_r.wdata[ttec_pkg::PRESC_W-1:0];
                    end
                end
                ttec_pkg::SEL_EDGE: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.edge_sel = s_r.wdata[1:0];
                    end
                end
                ttec_pkg::SEL_STAT: begin
                    if (s_r.wstrb[0] && s_r.wdata[ttec_pkg::ST_EDGE_BIT]) begin
                        s_nxt.edge_flag = 1'b0;
                    end
                end
                default: begin
                    s_nxt.bresp = ttec_pkg::RESP_SLVERR;
                end
            endcase
        end
        // a new edge beats a clear in the same cycle
        if (edge_valid) begin
            s_nxt.edge_flag = 1'b1;
        end
        if (s_r.rvalid && s_axi_rready_i) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = ttec_pkg::RESP_OKAY;
            s_nxt.rdata = ttec_pkg::ZERO_WORD;
            case (ttec_reg_sel(s_axi_araddr_i))
                ttec_pkg::SEL_CTRL: begin
                    s_nxt.rdata[ttec_pkg::CTRL_RUN_BIT] = s_r.run;
                    s_nxt.rdata[ttec_pkg::CTRL_ONESHOT_BIT] = s_r.oneshot_mode;
                    s_nxt.rdata[ttec_pkg::CTRL_EXTCLK_BIT] = s_r.ext_clk;
                    s_nxt.rdata[ttec_pkg::CTRL_CLRSTART_BIT] = s_r.clr_start;
                    s_nxt.rdata[ttec_pkg::CTRL_CAPTURE_BIT] = s_r.cap_en;
                end
                ttec_pkg::SEL_OUT: begin
                    // set, reset and trigger bits are left at zero [RULE10] [RULE11]
                    s_nxt.rdata[ttec_pkg::OC_ENABLE_BIT] = s_r.out_en;
                end
                ttec_pkg::SEL_PRESC: begin
                    s_nxt.rdata[ttec_pkg::PRESC_W-1:0] = s_r.presc;
                end
                ttec_pkg::SEL_EDGE: begin
                    s_nxt.rdata[1:0] = s_r.edge_sel;
                end
                ttec_pkg::SEL_STAT: begin
                    s_nxt.rdata[ttec_pkg::ST_EDGE_BIT] = s_r.edge_flag;
                    s_nxt.rdata[ttec_pkg::ST_INPUT_BIT] = external_trigger_input_i;
                    s_nxt.rdata[ttec_pkg::ST_LEVEL_BIT] = s_r.out_level;
                end
                default: begin
                    s_nxt.rresp = ttec_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_bvalid_o = s_r.bvalid;
    assign s_axi_bresp_o = s_r.bresp;
    assign s_axi_rvalid_o = s_r.rvalid;
    assign s_axi_rdata_o = s_r.rdata;
    assign s_axi_rresp_o = s_r.rresp;
    assign timer_run_o = s_r.run;
    assign oneshot_mode_o = s_r.oneshot_mode;
    // no gating by mode or spacing: software keeps those [RULE1] [RULE2]
    assign oneshot_soft_trigger_o = s_r.trig;
    assign count_tick_o = s_r.run && (s_r.ext_clk ? edge_valid : presc_tick);
    // pin edge is not reused when it already clocks the counter [RULE6]
    assign clear_start_o = s_r.run && s_r.clr_start && !s_r.ext_clk && edge_valid;
    assign capture_o = s_r.run && s_r.cap_en && !s_r.ext_clk && edge_valid;
    assign timer_output_enable_o = s_r.out_en;
    assign output_level_o = s_r.out_level;

    // ==========================================================
    // checks
    a_trig_self_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE10]
        oneshot_soft_trigger_o |=> !oneshot_soft_trigger_o)
        else $error("soft trigger held longer than one cycle");
    a_out_reads_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE11]
        ar_hs && s_axi_araddr_i == ttec_pkg::OUTPUT_CTRL_OFS |=>
        s_axi_rvalid_o && s_axi_rdata_o[ttec_pkg::OC_TRIG_BIT:ttec_pkg::OC_SET_BIT] == 3'h0)
        else $error("set, reset or trigger bit read as one");
    a_level_set_alone: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE4]
        s_r.aw_got && s_r.w_got && s_r.awaddr == ttec_pkg::OUTPUT_CTRL_OFS && s_r.wstrb[0] &&
        s_r.wdata[ttec_pkg::OC_SET_BIT] |=> output_level_o && s_axi_bvalid_o)
        else $error("output level set not taken");
    a_trig_from_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE10]
        oneshot_soft_trigger_o |-> $past(s_r.aw_got) && $past(s_r.w_got)
        && $past(s_r.awaddr) == ttec_pkg::OUTPUT_CTRL_OFS)
        else $error("soft trigger without a write");
    c_trig_written: cover property (@(posedge mclk_i) disable iff (!rst_n_i) oneshot_soft_trigger_o);
    c_ext_count: cover property (@(posedge mclk_i) disable iff (!rst_n_i) s_r.ext_clk && count_tick_o);
endmodule : ttec_top
`default_nettype wire

// [tb/ttec_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// external trigger pin driver
module ttec_pin_model (
    // clock
    input wire logic mclk_i,
    // requested level
    input wire logic level_req_i,
    // pin
    output logic external_trigger_input_o
);
    // pin moves only after a clock edge, never mid-cycle, so each level holds a full cycle
    always_ff @(posedge mclk_i) begin
        external_trigger_input_o <= level_req_i;
    end
endmodule : ttec_pin_model
`default_nettype wire

// [tb/ttec_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module ttec_top_bench;
    // ==========================================================
    // signals
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
    logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, resp;
    logic pin_req = 1'b1, pin;
    logic run, osm, tick, trig, clr, cap, oe, lvl;
    logic [31:0] rd;
    int mismatches = 0, compares = 0, n_tick = 0, n_trig = 0, n_clr = 0, n_cap = 0, t0;

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    ttec_pin_model i_pin (.mclk_i(mclk_i), .level_req_i(pin_req), .external_trigger_input_o(pin));

    ttec_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .external_trigger_input_i(pin), .timer_run_o(run), .oneshot_mode_o(osm), .count_tick_o(tick),
        .oneshot_soft_trigger_o(trig), .clear_start_o(clr), .capture_o(cap),
        .timer_output_enable_o(oe), .output_level_o(lvl));

    // pulse counters, sampled at the edge that sees them
    always @(posedge mclk_i) begin
        n_tick <= n_tick + (tick === 1'b1);
        n_trig <= n_trig + (trig === 1'b1);
        n_clr <= n_clr + (clr === 1'b1);
        n_cap <= n_cap + (cap === 1'b1);
    end

    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ah, wh;
        ah = 1'b0;
        wh = 1'b0;
        @(posedge mclk_i);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        while (!(ah && wh)) begin
            @(posedge mclk_i);
            if (!ah && awready === 1'b1) begin
                ah = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wh && wready === 1'b1) begin
                wh = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk_i); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge mclk_i);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge mclk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk_i); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic pin_set(input logic v);
        @(posedge mclk_i);
        pin_req <= v;
        repeat (4) @(posedge mclk_i);
    endtask : pin_set

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        end_sim();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        chk("run after reset", {31'h0, run}, 32'h0000_0000);
        rdr(ttec_pkg::TIMER_CTRL_OFS);
        chk("ctrl reset", rd, 32'h0000_0000);
        // pin high since reset, counting on rising pin edges
        wr(ttec_pkg::EDGE_SEL_OFS, 32'h0000_0001, 4'hf);
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0005, 4'hf);
        chk("run after enable", {31'h0, run}, 32'h0000_0001);
        pin_set(1'b1);
        chk("tick at first enable", n_tick, 32'h0000_0001);
        pin_set(1'b0);
        chk("fall ignored on rise", n_tick, 32'h0000_0001);
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0004, 4'hf);
        pin_set(1'b1);
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0005, 4'hf);
        pin_set(1'b1);
        chk("rise on reenable", n_tick, 32'h0000_0002);
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0004, 4'hf);
        wr(ttec_pkg::EDGE_SEL_OFS, 32'h0000_0000, 4'hf);
        pin_set(1'b0);
        pin_set(1'b1);
        pin_set(1'b0);
        chk("no edge while stopped", n_tick, 32'h0000_0002);
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0005, 4'hf);
        pin_set(1'b0);
        chk("fall on reenable", n_tick, 32'h0000_0003);
        wr(ttec_pkg::EDGE_SEL_OFS, 32'h0000_0003, 4'hf);
        pin_set(1'b1);
        pin_set(1'b0);
        chk("both edges", n_tick, 32'h0000_0005);
        wr(ttec_pkg::EDGE_SEL_OFS, 32'h0000_0002, 4'hf);
        pin_set(1'b1);
        chk("no edge selected", n_tick, 32'h0000_0005);
        // clear and capture on the pin only with internal count clock
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0000, 4'hf);
        wr(ttec_pkg::EDGE_SEL_OFS, 32'h0000_0001, 4'hf);
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0019, 4'hf);
        pin_set(1'b0);
        pin_set(1'b1);
        chk("clear start pulses", n_clr, 32'h0000_0001);
        chk("capture pulses", n_cap, 32'h0000_0001);
        // prescaler: stop, select, run, count ticks over 80 clocks
        for (int p = 0; p < 4; p++) begin
            wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0000, 4'hf);
            wr(ttec_pkg::PRESCALER_SEL_OFS, p, 4'hf);
            wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0001, 4'hf);
            @(negedge mclk_i);
            t0 = n_tick;
            repeat (80) @(negedge mclk_i);
            chk("prescaled ticks", n_tick - t0, 32'd80 >> p);
        end
        // soft trigger in one-shot mode, writes spaced well past two count clocks
        wr(ttec_pkg::TIMER_CTRL_OFS, 32'h0000_0002, 4'hf);
        chk("oneshot mode", {31'h0, osm}, 32'h0000_0001);
        wr(ttec_pkg::OUTPUT_CTRL_OFS, 32'h0000_0008, 4'hf);
        repeat (20) @(posedge mclk_i);
        wr(ttec_pkg::OUTPUT_CTRL_OFS, 32'h0000_0008, 4'hf);
        repeat (2) @(posedge mclk_i);
        chk("trigger pulses", n_trig, 32'h0000_0002);
        rdr(ttec_pkg::OUTPUT_CTRL_OFS);
        chk("trigger reads zero", rd, 32'h0000_0000);
        // output disabled: enable, set and reset in one byte write, set wins
        wr(ttec_pkg::OUTPUT_CTRL_OFS, 32'h0000_0007, 4'h1);
        chk("output enable", {31'h0, oe}, 32'h0000_0001);
        chk("level after set", {31'h0, lvl}, 32'h0000_0001);
        wr(ttec_pkg::OUTPUT_CTRL_OFS, 32'h0000_0005, 4'h1);
        chk("level after reset", {31'h0, lvl}, 32'h0000_0000);
        wr(ttec_pkg::OUTPUT_CTRL_OFS, 32'h0000_0003, 4'h1);
        chk("level after set", {31'h0, lvl}, 32'h0000_0001);
        rdr(ttec_pkg::OUTPUT_CTRL_OFS);
        chk("set reset read zero", rd, 32'h0000_0001);
        // no byte lane: nothing stored
        wr(ttec_pkg::OUTPUT_CTRL_OFS, 32'h0000_0000, 4'h0);
        chk("strobe off keeps enable", {31'h0, oe}, 32'h0000_0001);
        chk("strobe off write resp", {30'h0, resp}, {30'h0, ttec_pkg::RESP_OKAY});
        wr(8'h20, 32'h0000_00ff, 4'hf);
        chk("unmapped write resp", {30'h0, resp}, {30'h0, ttec_pkg::RESP_SLVERR});
        rdr(8'h20);
        chk("unmapped read resp", {30'h0, resp}, {30'h0, ttec_pkg::RESP_SLVERR});
        chk("unmapped read data", rd, ttec_pkg::ZERO_WORD);
        // status: sticky edge flag from earlier runs, pin high, level set; timer stopped so no new edge
        rdr(ttec_pkg::STATUS_OFS);
        chk("status flag pin level", rd, 32'h0000_0007);
        wr(ttec_pkg::STATUS_OFS, 32'h0000_0001, 4'hf);
        rdr(ttec_pkg::STATUS_OFS);
        chk("status flag cleared", rd, 32'h0000_0006);
        end_sim();
    end
endmodule : ttec_top_bench
`default_nettype wire
